//--- logic/port_io_pkg.sv
// constants shared by the port i/o block and its pin cell
package port_io_pkg;

    localparam int PORT_WIDTH = 8;
    localparam int NREG       = 12;

    // register index in the storage array
    localparam int IDX_P0_LATCH  = 0;
    localparam int IDX_P1_LATCH  = 1;
    localparam int IDX_P0_DRIVE  = 2;
    localparam int IDX_P1_DRIVE  = 3;
    localparam int IDX_P0_MASK   = 4;
    localparam int IDX_P0_BYPASS = 5;
    localparam int IDX_P1_BYPASS = 6;
    localparam int IDX_P0_MATCH  = 7;
    localparam int IDX_P0_ANALOG = 8;
    localparam int IDX_P1_ANALOG = 9;
    localparam int IDX_P1_MASK   = 10;
    localparam int IDX_P1_MATCH  = 11;

    // special function register addresses
    localparam logic [7:0] ADDR_P0_LATCH  = 8'h80;
    localparam logic [7:0] ADDR_P1_LATCH  = 8'h90;
    localparam logic [7:0] ADDR_P0_DRIVE  = 8'ha4;
    localparam logic [7:0] ADDR_P1_DRIVE  = 8'ha5;
    localparam logic [7:0] ADDR_P0_MASK   = 8'hc7;
    localparam logic [7:0] ADDR_P0_BYPASS = 8'hd4;
    localparam logic [7:0] ADDR_P1_BYPASS = 8'hd5;
    localparam logic [7:0] ADDR_P0_MATCH  = 8'hd7;
    localparam logic [7:0] ADDR_P0_ANALOG = 8'hf1;
    localparam logic [7:0] ADDR_P1_ANALOG = 8'hf2;
    localparam logic [7:0] ADDR_P1_MASK   = 8'hbf;
    localparam logic [7:0] ADDR_P1_MATCH  = 8'hcf;

    // reset values
    localparam logic [7:0] RST_LATCH  = 8'hff;
    localparam logic [7:0] RST_DRIVE  = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h00;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [7:0] RST_MATCH  = 8'hff;
    localparam logic [7:0] RST_ANALOG = 8'hff;
    localparam logic [7:0] RST_RDATA  = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
    localparam logic       PIN_IDLE_LEVEL = 1'b1;
    localparam logic       PULLUP_RST     = 1'b1;
    localparam logic       DRIVE_OFF      = 1'b0;

    // bit address = byte address with the low bits replaced by the bit index
    localparam int BIT_IDX_W = 3;

    localparam logic [7:0] REG_ADDR [NREG] = '{
        ADDR_P0_LATCH, ADDR_P1_LATCH, ADDR_P0_DRIVE, ADDR_P1_DRIVE,
        ADDR_P0_MASK, ADDR_P0_BYPASS, ADDR_P1_BYPASS, ADDR_P0_MATCH,
        ADDR_P0_ANALOG, ADDR_P1_ANALOG, ADDR_P1_MASK, ADDR_P1_MATCH};

    localparam logic [7:0] REG_RST [NREG] = '{
        RST_LATCH, RST_LATCH, RST_DRIVE, RST_DRIVE,
        RST_MASK, RST_BYPASS, RST_BYPASS, RST_MATCH,
        RST_ANALOG, RST_ANALOG, RST_MASK, RST_MATCH};

    // only the two port latches answer bit accesses
    localparam logic [NREG-1:0] REG_BIT_ACCESS = 12'h003;

endpackage

//--- logic/port_io_with_match.sv
// two 8-bit i/o ports with sfr access and port match detection
//
// Operation
// - port write stores value in output latch
// - plain port read returns present pin levels
// - read-modify-write reads latch instead of pins
// - port latches reachable by byte and bit
// - masked pins differing from match raise event
// - match event requests interrupt and wakes oscillator
// - latch 0 drives low, 1 high or float
// - analog pin reads 0, digital reads level
// - input mode 0 makes pin fully analog
// - drive mode 0 open-drain, ignored when analog
// - two-wire bus pins always open-drain
// - skip bit makes crossbar pass the pin
// - mask 0 excludes pin from match compare
// - latch reaches pin only as crossbar allows
// - crossbar disabled keeps every driver off
// - weak pullup only on idle open-drain pins
`timescale 1ns/100ps
module port_io_with_match
    import port_io_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic             sfr_rmw,
    input  wire logic [7:0]       sfr_wdata,
    output logic      [7:0]       sfr_rdata,
    input  wire logic [7:0]       sfr_bit_addr,
    input  wire logic             sfr_bit_wr,
    input  wire logic             sfr_bit_rd,
    input  wire logic             sfr_bit_wdata,
    output logic                  sfr_bit_rdata,
    input  wire logic             crossbar_enable,
    input  wire logic             weak_pullup_disable,
    input  wire logic             match_interrupt_enable,
    input  wire logic [WIDTH-1:0] p0_xbar_claim,
    input  wire logic [WIDTH-1:0] p0_xbar_data,
    input  wire logic [WIDTH-1:0] p0_xbar_force_od,
    input  wire logic [WIDTH-1:0] p1_xbar_claim,
    input  wire logic [WIDTH-1:0] p1_xbar_data,
    input  wire logic [WIDTH-1:0] p1_xbar_force_od,
    input  wire logic [WIDTH-1:0] p0_pin_in,
    output logic      [WIDTH-1:0] p0_pin_out,
    output logic      [WIDTH-1:0] p0_pin_oe,
    output logic      [WIDTH-1:0] p0_pullup_en,
    input  wire logic [WIDTH-1:0] p1_pin_in,
    output logic      [WIDTH-1:0] p1_pin_out,
    output logic      [WIDTH-1:0] p1_pin_oe,
    output logic      [WIDTH-1:0] p1_pullup_en,
    output logic      [WIDTH-1:0] p0_skip,
    output logic      [WIDTH-1:0] p1_skip,
    output logic                  match_event,
    output logic                  match_irq,
    output logic                  osc_wake
);

    logic [7:0]       regs_reg  [NREG];
    logic [7:0]       regs_next [NREG];
    logic [7:0]       view      [NREG];
    logic [7:0]       rd_chain  [NREG+1];
    logic [NREG:0]    bit_chain;
    logic [NREG-1:0]  byte_hit;
    logic [NREG-1:0]  bit_hit;
    logic [7:0]       bit_onehot;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic             any_hit;
    logic             any_bit_hit;
    logic [7:0]       rdata_reg;
    logic             bit_rdata_reg;
    logic             event_reg;
    logic             irq_reg;
    logic             wake_reg;
    logic [WIDTH-1:0] p0_level;
    logic [WIDTH-1:0] p1_level;
    logic             p0_mismatch;
    logic             p1_mismatch;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and register storage
    assign bit_idx    = sfr_bit_addr[BIT_IDX_W-1:0];
    assign bit_onehot = 8'h01 << bit_idx;
    assign rd_chain[0]  = UNMAPPED_RDATA;
    assign bit_chain[0] = 1'b0;

    for (genvar i = 0; i < NREG; i++) begin : g_reg
        assign byte_hit[i] = sfr_addr == REG_ADDR[i];
        assign bit_hit[i]  = REG_BIT_ACCESS[i] &&
                             sfr_bit_addr[7:BIT_IDX_W] == REG_ADDR[i][7:BIT_IDX_W];
        // byte write wins over a bit write in the same cycle
        assign regs_next[i] = (sfr_wr && byte_hit[i]) ? sfr_wdata :
                              (sfr_bit_wr && bit_hit[i]) ?
                              ((regs_reg[i] & ~bit_onehot) |
                               ({8{sfr_bit_wdata}} & bit_onehot)) :
                              regs_reg[i];
        assign rd_chain[i+1]  = rd_chain[i] | (byte_hit[i] ? view[i] : 8'h00);
        assign bit_chain[i+1] = bit_chain[i] | (bit_hit[i] & view[i][bit_idx]);
    end

    // latches read back the pins unless the access is read-modify-write
    assign view[IDX_P0_LATCH]  = sfr_rmw ? regs_reg[IDX_P0_LATCH] : p0_level;
    assign view[IDX_P1_LATCH]  = sfr_rmw ? regs_reg[IDX_P1_LATCH] : p1_level;
    assign view[IDX_P0_DRIVE]  = regs_reg[IDX_P0_DRIVE];
    assign view[IDX_P1_DRIVE]  = regs_reg[IDX_P1_DRIVE];
    assign view[IDX_P0_MASK]   = regs_reg[IDX_P0_MASK];
    assign view[IDX_P0_BYPASS] = regs_reg[IDX_P0_BYPASS];
    assign view[IDX_P1_BYPASS] = regs_reg[IDX_P1_BYPASS];
    assign view[IDX_P0_MATCH]  = regs_reg[IDX_P0_MATCH];
    assign view[IDX_P0_ANALOG] = regs_reg[IDX_P0_ANALOG];
    assign view[IDX_P1_ANALOG] = regs_reg[IDX_P1_ANALOG];
    assign view[IDX_P1_MASK]   = regs_reg[IDX_P1_MASK];
    assign view[IDX_P1_MATCH]  = regs_reg[IDX_P1_MATCH];

    assign any_hit     = |byte_hit;
    assign any_bit_hit = |bit_hit;

    always_ff @(posedge clk) begin
        if (reset) begin
            regs_reg <= REG_RST;
        end else begin
            regs_reg <= regs_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, held until the next read of its kind
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg     <= RST_RDATA;
            bit_rdata_reg <= 1'b0;
        end else begin
            if (sfr_rd) begin
                rdata_reg <= any_hit ? rd_chain[NREG] : UNMAPPED_RDATA;
            end
            if (sfr_bit_rd) begin
                bit_rdata_reg <= any_bit_hit & bit_chain[NREG];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin cells
    port_pin_cell #(.WIDTH(WIDTH)) u_port0 (
        .clk         (clk),
        .reset       (reset),
        .pin_in      (p0_pin_in),
        .latch       (regs_reg[IDX_P0_LATCH][WIDTH-1:0]),
        .digital_sel (regs_reg[IDX_P0_ANALOG][WIDTH-1:0]),
        .push_pull   (regs_reg[IDX_P0_DRIVE][WIDTH-1:0]),
        .claim       (p0_xbar_claim),
        .periph_data (p0_xbar_data),
        .force_od    (p0_xbar_force_od),
        .mask        (regs_reg[IDX_P0_MASK][WIDTH-1:0]),
        .match_val   (regs_reg[IDX_P0_MATCH][WIDTH-1:0]),
        .xbar_en     (crossbar_enable),
        .weak_pud    (weak_pullup_disable),
        .pin_out     (p0_pin_out),
        .pin_oe      (p0_pin_oe),
        .pullup_en   (p0_pullup_en),
        .level       (p0_level),
        .mismatch    (p0_mismatch)
    );

    port_pin_cell #(.WIDTH(WIDTH)) u_port1 (
        .clk         (clk),
        .reset       (reset),
        .pin_in      (p1_pin_in),
        .latch       (regs_reg[IDX_P1_LATCH][WIDTH-1:0]),
        .digital_sel (regs_reg[IDX_P1_ANALOG][WIDTH-1:0]),
        .push_pull   (regs_reg[IDX_P1_DRIVE][WIDTH-1:0]),
        .claim       (p1_xbar_claim),
        .periph_data (p1_xbar_data),
        .force_od    (p1_xbar_force_od),
        .mask        (regs_reg[IDX_P1_MASK][WIDTH-1:0]),
        .match_val   (regs_reg[IDX_P1_MATCH][WIDTH-1:0]),
        .xbar_en     (crossbar_enable),
        .weak_pud    (weak_pullup_disable),
        .pin_out     (p1_pin_out),
        .pin_oe      (p1_pin_oe),
        .pullup_en   (p1_pullup_en),
        .level       (p1_level),
        .mismatch    (p1_mismatch)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // match event; a level, so a held mismatch keeps the wake request up
    always_ff @(posedge clk) begin
        if (reset) begin
            event_reg <= 1'b0;
            irq_reg   <= 1'b0;
            wake_reg  <= 1'b0;
        end else begin
            event_reg <= p0_mismatch | p1_mismatch;
            irq_reg   <= (p0_mismatch | p1_mismatch) & match_interrupt_enable;
            wake_reg  <= p0_mismatch | p1_mismatch;
        end
    end

    assign sfr_rdata     = rdata_reg;
    assign sfr_bit_rdata = bit_rdata_reg;
    assign match_event   = event_reg;
    assign match_irq     = irq_reg;
    assign osc_wake      = wake_reg;
    assign p0_skip       = regs_reg[IDX_P0_BYPASS][WIDTH-1:0];
    assign p1_skip       = regs_reg[IDX_P1_BYPASS][WIDTH-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_p0_pin_read;
        sfr_rd && sfr_addr == ADDR_P0_LATCH && !sfr_rmw;
    endsequence

    sequence s_p0_rmw_read;
        sfr_rd && sfr_addr == ADDR_P0_LATCH && sfr_rmw;
    endsequence

    sequence s_p1_bit_set;
        sfr_bit_wr && !sfr_wr && sfr_bit_addr[7:BIT_IDX_W] == ADDR_P1_LATCH[7:BIT_IDX_W]
            && sfr_bit_wdata;
    endsequence

    property p_latch_write;
        sfr_wr && sfr_addr == ADDR_P0_LATCH |=> regs_reg[IDX_P0_LATCH] == $past(sfr_wdata);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("port 0 latch did not take the written byte");

    property p_pin_read;
        s_p0_pin_read |=> sfr_rdata == $past(p0_level);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("port 0 read did not return the pin levels");

    property p_rmw_read;
        s_p0_rmw_read |=> sfr_rdata == $past(regs_reg[IDX_P0_LATCH]);
    endproperty
    a_rmw_read: assert property (p_rmw_read)
        else $error("read-modify-write did not return the latch");

    property p_bit_write;
        s_p1_bit_set ##1 1'b1 |-> regs_reg[IDX_P1_LATCH][$past(bit_idx)];
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("bit write did not set the port 1 latch bit");

    property p_match_event;
        (p0_mismatch || p1_mismatch) |=> match_event && osc_wake;
    endproperty
    a_match_event: assert property (p_match_event)
        else $error("mismatch did not raise the match event");

    property p_irq_gate;
        match_event |-> match_irq == $past(match_interrupt_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("match interrupt does not follow its enable");

    property p_od_high;
        1'b1 |=> (p0_pin_out & ~$past(regs_reg[IDX_P0_DRIVE][WIDTH-1:0])) == '0;
    endproperty
    a_od_high: assert property (p_od_high)
        else $error("open-drain pin driven high");

    property p_analog_read;
        s_p0_pin_read ##1 1'b1 |-> (sfr_rdata & ~$past(regs_reg[IDX_P0_ANALOG], 2)) == 8'h00;
    endproperty
    a_analog_read: assert property (p_analog_read)
        else $error("analog pin read back non-zero");

    property p_analog_off;
        1'b1 |=> (p0_pin_oe & ~$past(regs_reg[IDX_P0_ANALOG][WIDTH-1:0])) == '0;
    endproperty
    a_analog_off: assert property (p_analog_off)
        else $error("analog pin has its driver on");

    property p_two_wire_od;
        1'b1 |=> (p0_pin_out & $past(p0_xbar_force_od)) == '0;
    endproperty
    a_two_wire_od: assert property (p_two_wire_od)
        else $error("two-wire bus pin driven high");

    property p_mask_zero;
        regs_reg[IDX_P0_MASK] == 8'h00 && regs_reg[IDX_P1_MASK] == 8'h00
            ##1 1'b1 |-> !p0_mismatch && !p1_mismatch;
    endproperty
    a_mask_zero: assert property (p_mask_zero)
        else $error("fully masked port raised a mismatch");

    property p_xbar_off;
        !crossbar_enable |=> p0_pin_oe == '0 && p1_pin_oe == '0;
    endproperty
    a_xbar_off: assert property (p_xbar_off)
        else $error("driver enabled while crossbar is off");

    property p_pullup;
        weak_pullup_disable |=> p0_pullup_en == '0 && p1_pullup_en == '0;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pullup on while pullups are disabled");

endmodule

//--- logic/port_pin_cell.sv
// one port: input synchroniser, pin drive, pullup and masked compare
`timescale 1ns/100ps
module port_pin_cell
    import port_io_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] digital_sel,
    input  wire logic [WIDTH-1:0] push_pull,
    input  wire logic [WIDTH-1:0] claim,
    input  wire logic [WIDTH-1:0] periph_data,
    input  wire logic [WIDTH-1:0] force_od,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic [WIDTH-1:0] match_val,
    input  wire logic             xbar_en,
    input  wire logic             weak_pud,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] pullup_en,
    output logic      [WIDTH-1:0] level,
    output logic                  mismatch
);

    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] out_next;
    logic [WIDTH-1:0] oe_next;
    logic [WIDTH-1:0] pu_next;
    logic [WIDTH-1:0] level_next;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] oe_reg;
    logic [WIDTH-1:0] pu_reg;
    logic [WIDTH-1:0] level_reg;
    logic             mismatch_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // per-pin drive decision
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        wire open_drain = ~push_pull[i] | force_od[i];
        wire value      = claim[i] ? periph_data[i] : latch[i];
        wire drive_en   = xbar_en & digital_sel[i];
        // open drain only ever pulls low; a high is left to the pullup
        assign oe_next[i]    = drive_en & (~value | ~open_drain);
        assign out_next[i]   = drive_en & ~open_drain & value;
        assign pu_next[i]    = ~weak_pud & digital_sel[i] & open_drain
                               & ~(drive_en & ~value);
        assign level_next[i] = sync2_reg[i] & digital_sel[i];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_reg    <= {WIDTH{PIN_IDLE_LEVEL}};
            sync2_reg    <= {WIDTH{PIN_IDLE_LEVEL}};
            out_reg      <= {WIDTH{DRIVE_OFF}};
            oe_reg       <= {WIDTH{DRIVE_OFF}};
            pu_reg       <= {WIDTH{PULLUP_RST}};
            level_reg    <= {WIDTH{PIN_IDLE_LEVEL}};
            mismatch_reg <= 1'b0;
        end else begin
            sync1_reg    <= pin_in;
            sync2_reg    <= sync1_reg;
            out_reg      <= out_next;
            oe_reg       <= oe_next;
            pu_reg       <= pu_next;
            level_reg    <= level_next;
            mismatch_reg <= |((level_reg ^ match_val) & mask);
        end
    end

    assign pin_out   = out_reg;
    assign pin_oe    = oe_reg;
    assign pullup_en = pu_reg;
    assign level     = level_reg;
    assign mismatch  = mismatch_reg;

endmodule

//--- testbench/board_pins.sv
// board side of one port: pads, external drivers, pullups and floating lines
`timescale 1ns/100ps
module board_pins (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    initial pin_in = 8'hff;

    ////////////////////////////////////////////////////////////////////////////////
    // a floating pad shows the inverse of its last level, never a kind default
    always @(pin_out, pin_oe, pullup_en, ext_en, ext_val) begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ~pin_in[i];
            end
        end
    end
endmodule

//--- testbench/port_io_with_match_tb.sv
// self-checking bench for the two-port i/o block with match detection
`timescale 1ns/100ps
module port_io_with_match_tb;
    import port_io_pkg::*;

    logic       clk = 1'b0;
    logic       reset;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
    logic       sfr_bit_wr = 1'b0, sfr_bit_rd = 1'b0, sfr_bit_wdata = 1'b0;
    logic       xe = 1'b0, wpd = 1'b0, mie = 1'b0;
    logic [7:0] claim [2] = '{8'h00, 8'h00};
    logic [7:0] xdata [2] = '{8'h00, 8'h00};
    logic [7:0] fod [2] = '{8'h00, 8'h00};
    logic [7:0] ext_v [2] = '{8'hff, 8'hff};
    logic [7:0] ext_e [2] = '{8'hff, 8'hff};
    logic [7:0] pin_in [2], pin_out [2], pin_oe [2], pull [2], skip [2];
    logic [7:0] sfr_rdata, q, oe_e, po_e, pu_e;
    logic [7:0] lv_e [2];
    logic [7:0] mdl [NREG];
    logic [7:0] wv [NREG];
    logic       sfr_bit_rdata, match_event, match_irq, osc_wake, qb, mm;
    int         errors = 0;
    int         num_checks = 0;
    int         seed = 5;

    always #12.5 clk = ~clk;

    port_io_with_match port_io_with_match_i (
        .clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_rd(sfr_bit_rd),
        .sfr_bit_wdata(sfr_bit_wdata), .sfr_bit_rdata(sfr_bit_rdata),
        .crossbar_enable(xe), .weak_pullup_disable(wpd), .match_interrupt_enable(mie),
        .p0_xbar_claim(claim[0]), .p0_xbar_data(xdata[0]), .p0_xbar_force_od(fod[0]),
        .p1_xbar_claim(claim[1]), .p1_xbar_data(xdata[1]), .p1_xbar_force_od(fod[1]),
        .p0_pin_in(pin_in[0]), .p0_pin_out(pin_out[0]), .p0_pin_oe(pin_oe[0]),
        .p0_pullup_en(pull[0]), .p1_pin_in(pin_in[1]), .p1_pin_out(pin_out[1]),
        .p1_pin_oe(pin_oe[1]), .p1_pullup_en(pull[1]), .p0_skip(skip[0]), .p1_skip(skip[1]),
        .match_event(match_event), .match_irq(match_irq), .osc_wake(osc_wake));

    for (genvar g = 0; g < 2; g++) begin : g_port
        board_pins board_pins_i (.pin_out(pin_out[g]), .pin_oe(pin_oe[g]),
            .pullup_en(pull[g]), .ext_en(ext_e[g]), .ext_val(ext_v[g]), .pin_in(pin_in[g]));
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // every access starts just after an edge and ends just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        for (int i = 0; i < NREG; i++) if (REG_ADDR[i] == a) mdl[i] = d;
        @(posedge clk);
        #2 sfr_wr = 1'b0;
        // one idle edge, so no strobe falls and rises in the same step
        @(posedge clk);
        #2;
    endtask

    task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
        sfr_addr = a;
        sfr_rmw = m;
        sfr_rd = 1'b1;
        @(posedge clk);
        #2 sfr_rd = 1'b0;
        d = sfr_rdata;
        @(posedge clk);
        #2;
    endtask

    task automatic bit_acc(input logic [7:0] a, input logic w, input logic v, input logic m);
        sfr_bit_addr = a;
        sfr_bit_wdata = v;
        sfr_rmw = m;
        sfr_bit_wr = w;
        sfr_bit_rd = ~w;
        if (w && a[7:3] == 5'h10) mdl[0][a[2:0]] = v;
        if (w && a[7:3] == 5'h12) mdl[1][a[2:0]] = v;
        @(posedge clk);
        #2 sfr_bit_wr = 1'b0;
        sfr_bit_rd = 1'b0;
        qb = sfr_bit_rdata;
        @(posedge clk);
        #2;
    endtask

    // expected pad behaviour of port p from the model registers and inputs
    task automatic calc(input int p, output logic [7:0] oe, po, pu, lv);
        logic [7:0] val, od, dig;
        dig = mdl[IDX_P0_ANALOG + p];
        val = (claim[p] & xdata[p]) | (~claim[p] & mdl[p]);
        od = ~mdl[IDX_P0_DRIVE + p] | fod[p];
        oe = {8{xe}} & dig & (~od | ~val);
        po = val & ~od & oe;
        // pullup stays on with the crossbar off, since nothing then drives low
        pu = {8{~wpd}} & dig & od & ~oe;
        lv = ((oe & po) | (~oe & ((ext_e[p] & ext_v[p]) | (~ext_e[p] & pu))))
             & dig;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reset for six edges, one idle edge, then every register at its reset value
    task automatic reset_and_check();
        reset = 1'b1;
        for (int i = 0; i < NREG; i++) mdl[i] = REG_RST[i];
        repeat (6) @(posedge clk);
        #2 reset = 1'b0;
        @(posedge clk);
        #2;
        for (int i = 0; i < NREG; i++) begin
            rd(REG_ADDR[i], 1'b1, q);
            chk(q, REG_RST[i], "reset value");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 20000);
        errors++;
        print_verdict();
    end

    initial begin
        reset_and_check();
        wr(8'h81, 8'h5a);
        rd(8'h81, 1'b0, q);
        chk(q, 8'h00, "unmapped read");
        for (int it = 0; it < 40; it++) begin
            if (it == 20) reset_and_check();
            for (int i = 0; i < NREG; i++) wv[i] = 8'($random(seed));
            // a quarter of passes mask everything off, a quarter set the board drive values to the match
            if (it % 4 == 2) wv[IDX_P0_MASK] = 8'h00;
            if (it % 4 == 2) wv[IDX_P1_MASK] = 8'h00;
            if (it % 4 == 0) wv[IDX_P0_ANALOG] = 8'hff;
            if (it % 4 == 0) wv[IDX_P1_ANALOG] = 8'hff;
            wv[IDX_P0_BYPASS] = ~wv[IDX_P0_ANALOG];
            wv[IDX_P1_BYPASS] = ~wv[IDX_P1_ANALOG];
            for (int p = 0; p < 2; p++) begin
                claim[p] = 8'($random(seed));
                xdata[p] = 8'($random(seed));
                fod[p] = 8'($random(seed));
                ext_v[p] = 8'($random(seed));
            end
            if (it % 4 == 0) ext_v[0] = wv[IDX_P0_MATCH];
            if (it % 4 == 0) ext_v[1] = wv[IDX_P1_MATCH];
            xe = it[0];
            wpd = 1'($random(seed));
            mie = 1'($random(seed));
            for (int i = 0; i < NREG; i++) wr(REG_ADDR[i], wv[i]);
            bit_acc({it[1] ? 5'h12 : 5'h10, it[4:2]}, 1'b1, it[5] ^ it[0], 1'b0);
            bit_acc(8'hd3, 1'b1, 1'b1, 1'b0);
            // release random board drivers, but only where a pullup holds the pad
            for (int p = 0; p < 2; p++) begin
                calc(p, oe_e, po_e, pu_e, lv_e[p]);
                ext_e[p] = 8'($random(seed)) | ~pu_e;
            end
            repeat (6) @(posedge clk);
            #2;
            for (int p = 0; p < 2; p++) begin
                calc(p, oe_e, po_e, pu_e, lv_e[p]);
                chk(pin_oe[p], oe_e, "driver enable");
                chk(pin_out[p] & oe_e, po_e, "driven level");
                chk(pull[p], pu_e, "pullup");
                chk(skip[p], mdl[IDX_P0_BYPASS + p], "skip");
                rd(REG_ADDR[p], 1'b0, q);
                chk(q, lv_e[p], "pin read");
                rd(REG_ADDR[p], 1'b1, q);
                chk(q, mdl[p], "latch read");
                bit_acc({p ? 5'h12 : 5'h10, it[2:0]}, 1'b0, 1'b0, it[1]);
                chk({7'h0, qb}, {7'h0, it[1] ? mdl[p][it[2:0]] : lv_e[p][it[2:0]]}, "bit");
            end
            for (int i = 2; i < NREG; i++) begin
                rd(REG_ADDR[i], 1'b0, q);
                chk(q, mdl[i], "readback");
            end
            mm = |((lv_e[0] ^ mdl[IDX_P0_MATCH]) & mdl[IDX_P0_MASK])
                | |((lv_e[1] ^ mdl[IDX_P1_MATCH]) & mdl[IDX_P1_MASK]);
            chk({7'h0, match_event}, {7'h0, mm}, "match event");
            chk({7'h0, match_irq}, {7'h0, mm & mie}, "match irq");
            chk({7'h0, osc_wake}, {7'h0, mm}, "wake");
        end
        print_verdict();
    end
endmodule
